/* stp_serial_port.sv */
`timescale 1ns/1ps
// What this block does
// - with read padding on, 0 to 3 dummy bytes (the count field) go out before read data; the count resets to 1.
// - with read padding off (reset), read data follows the address phase directly.
// - output bit 0 drives on the edge opposite sampling, bit 1 adds half a serial clock.
// - sampling edge bit 0 samples on rising serial clock, 1 on falling; host matches.
// - spi is three-wire only on the shared data pin; the wire-mode bit stays 1.
// - the i2c speed field only selects output slew and drive strength.
// - scl and sda have spike filters of field-many system cycles, 0 disables, reset 1.
// - sending a 1 on sda is delayed by eight times the high-hold field, reset 4.
// - sending a 0 on sda is delayed by eight times the low-hold field, reset 4.
// - i2c accesses are acked only when the 7-bit address matches, default 0x09.
// - the two low address bits come from otp or startup straps, never from writes.
// - port mode: 0 off, 1 i2c (reset), 2 spi, 3 reserved.
// - register address is one byte (upper from page) or, in spi only, two bytes per the size bit; i2c then takes one byte as the upper half.
module stp_serial_port import stp_pkg::*; (
	input  wire logic       clk,            // system clock, 10 MHz
	input  wire logic       reset_n,        // async reset
	input  wire logic       scl_sclk,       // i2c clock / spi clock pin
	input  wire logic       cs_n,           // spi chip select pin
	input  wire logic       sdio_i,         // data pin level
	output logic            sdio_o,         // data pin drive value
	output logic            sdio_oe,        // data pin drive enable
	input  wire logic [1:0] otp_addr_lsb,   // address low bits from otp
	input  wire logic       strap_en,       // otp allows strap override
	input  wire logic [1:0] strap_addr,     // strap pins for address low bits
	output logic [1:0]      i2c_slew_sel,   // output driver slew select
	output logic [1:0]      port_mode       // active port mode
);
	typedef struct packed {
		logic [7:0]     spi_opt;
		logic [7:0]     fltr;
		logic [7:0]     tim;
		logic [4:0]     taddr_hi;
		logic [7:0]     glb;
		logic [7:0]     page;
		logic [1:0]     lsb;
		logic [1:0]     strap_s1;
		logic [1:0]     strap_s2;
		logic [1:0]     strap_cnt;
		logic           tog_s1;
		logic           tog_s2;
		logic           tog_s3;
		logic           scl_d;
		logic           sda_d;
		stp_i2c_state_t st;
		logic [3:0]     bitcnt;
		logic [7:0]     shift;
		logic           rw;
		logic           first;
		logic [15:0]    ptr;
		logic [7:0]     tx;
		logic           nack;
		logic           drv_low;
		logic           want_low;
		logic           pend;
		logic [6:0]     hold;
	} stp_port_state_t;

	stp_port_state_t q, d;
	logic scl_f, sda_f, spi_o, spi_oe, spi_tog;
	logic [15:0] spi_waddr;
	logic [7:0] spi_wdata, taddr;

	assign taddr = {1'b0, q.taddr_hi, q.lsb};

	stp_spike_filter u_scl_filt (
		.clk     (clk),
		.reset_n (reset_n),
		.pin_i   (scl_sclk),
		.len     (q.fltr[3:0]),
		.filt_o  (scl_f)
	);

	stp_spike_filter u_sda_filt (
		.clk     (clk),
		.reset_n (reset_n),
		.pin_i   (sdio_i),
		.len     (q.fltr[3:0]),
		.filt_o  (sda_f)
	);

	stp_spi_link u_spi (
		.sclk      (scl_sclk),
		.cs_n      (cs_n),
		.reset_n   (reset_n),
		.enable    (q.glb[1:0] == STP_MODE_SPI),
		.sdio_i    (sdio_i),
		.spi_opt   (q.spi_opt),
		.fltr      (q.fltr),
		.tim       (q.tim),
		.taddr     (taddr),
		.glb       (q.glb),
		.page      (q.page),
		.sdio_o    (spi_o),
		.sdio_oe   (spi_oe),
		.wr_toggle (spi_tog),
		.wr_addr   (spi_waddr),
		.wr_data   (spi_wdata)
	);

	always_comb begin
		logic        wr_en;
		logic [15:0] wr_a;
		logic [7:0]  wr_v;
		logic        rise, fall, start, stop, i2c_on;
		logic [7:0]  rx_byte;
		wr_en = 1'b0;
		wr_a = 16'h0000;
		wr_v = 8'h00;
		d = q;
		rise = scl_f && !q.scl_d;
		fall = !scl_f && q.scl_d;
		start = scl_f && q.scl_d && !sda_f && q.sda_d;
		stop = scl_f && q.scl_d && sda_f && !q.sda_d;
		i2c_on = q.glb[1:0] == STP_MODE_I2C;
		rx_byte = q.shift;
		d.scl_d = scl_f;
		d.sda_d = sda_f;

		// straps settle through two flops, then are taken once
		d.strap_s1 = strap_addr;
		d.strap_s2 = q.strap_s1;
		if (q.strap_cnt != STP_STRAP_WAIT + 2'h1) begin
			d.strap_cnt = q.strap_cnt + 2'h1;
			if (q.strap_cnt == STP_STRAP_WAIT)
				d.lsb = strap_en ? q.strap_s2 : otp_addr_lsb;
		end

		// spi writes cross by toggle; address and data are stable by then
		d.tog_s1 = spi_tog;
		d.tog_s2 = q.tog_s1;
		d.tog_s3 = q.tog_s2;

		// sda changes only after the programmed hold
		if (q.pend) begin
			if (q.hold == 7'h00) begin
				d.drv_low = q.want_low;
				d.pend = 1'b0;
			end else begin
				d.hold = q.hold - 7'h01;
			end
		end

		if (!i2c_on || start || stop) begin
			d.st = start && i2c_on ? STP_I2C_ADDR : STP_I2C_IDLE;
			d.bitcnt = 4'h0;
			d.drv_low = 1'b0;
			d.pend = 1'b0;
		end else begin
			if (rise) begin
				case (q.st)
				STP_I2C_ADDR, STP_I2C_RX: begin
					d.shift = {q.shift[6:0], sda_f};
					d.bitcnt = q.bitcnt + 4'h1;
				end
				STP_I2C_TX_ACK: d.nack = sda_f;
				default: d.nack = q.nack;
				endcase
			end
			if (fall) begin
				d.pend = 1'b1;
				d.want_low = 1'b0;
				case (q.st)
				STP_I2C_ADDR: begin
					if (q.bitcnt == 4'h8) begin
						if (rx_byte[7:1] == taddr[6:0]) begin
							d.st = STP_I2C_ADDR_ACK;
							d.want_low = 1'b1;
							d.rw = rx_byte[0];
							d.first = 1'b1;
						end else begin
							d.st = STP_I2C_IDLE;
						end
					end
				end
				STP_I2C_ADDR_ACK, STP_I2C_RX_ACK: begin
					d.bitcnt = 4'h0;
					if (q.rw) begin
						d.st = STP_I2C_TX;
						d.tx = stp_reg_read(q.ptr, q.page, q.spi_opt, q.fltr, q.tim, taddr, q.glb);
						d.want_low = !d.tx[7];
					end else begin
						d.st = STP_I2C_RX;
					end
				end
				STP_I2C_RX: begin
					if (q.bitcnt == 4'h8) begin
						d.st = STP_I2C_RX_ACK;
						d.want_low = 1'b1;
						if (q.first && q.glb[STP_ADDR_SIZE_BIT]) begin
							d.ptr[15:8] = rx_byte;
							d.first = 1'b0;
						end else if (q.first || q.bitcnt == 4'hf) begin
							d.ptr = {q.glb[STP_ADDR_SIZE_BIT] ? q.ptr[15:8] : q.page, rx_byte};
							d.first = 1'b0;
						end else begin
							wr_en = 1'b1;
							wr_a = q.ptr;
							wr_v = rx_byte;
							d.ptr = q.ptr + 16'h1;
						end
					end
				end
				STP_I2C_TX: begin
					if (q.bitcnt == 4'h7) begin
						d.st = STP_I2C_TX_ACK;
					end else begin
						d.bitcnt = q.bitcnt + 4'h1;
						d.tx = {q.tx[6:0], 1'b0};
						d.want_low = !d.tx[7];
					end
				end
				STP_I2C_TX_ACK: begin
					if (q.nack) begin
						d.st = STP_I2C_IDLE;
					end else begin
						d.st = STP_I2C_TX;
						d.bitcnt = 4'h0;
						d.ptr = q.ptr + 16'h1;
						d.tx = stp_reg_read(d.ptr, q.page, q.spi_opt, q.fltr, q.tim, taddr, q.glb);
						d.want_low = !d.tx[7];
					end
				end
				default: d.st = STP_I2C_IDLE;
				endcase
				// hold in cycles is eight times the field of the bit value
				d.hold = d.want_low ? {q.tim[3:0], 3'h0} :
					{q.tim[STP_HIGH_HOLD_LSB +: 4], 3'h0};
			end
		end

		if (!wr_en && (q.tog_s2 ^ q.tog_s3)) begin
			wr_en = 1'b1;
			wr_a = spi_waddr;
			wr_v = spi_wdata;
		end
		if (wr_en) begin
			if (wr_a[7:0] == STP_PAGE_LO) d.page = wr_v;
			else if (wr_a == STP_SPI_OPT_ADDR)
				d.spi_opt = (wr_v & STP_SPI_OPT_WMASK) | STP_SPI_OPT_FIXED;
			else if (wr_a == STP_FLTR_ADDR) d.fltr = wr_v & STP_FLTR_WMASK;
			else if (wr_a == STP_TIM_ADDR) d.tim = wr_v;
			else if (wr_a == STP_TADDR_ADDR) d.taddr_hi = wr_v[6:2];
			else if (wr_a == STP_GLOBAL_ADDR) d.glb = wr_v & STP_GLOBAL_WMASK;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			q <= '0;
			q.spi_opt <= STP_SPI_OPT_RST;
			q.fltr <= STP_FLTR_RST;
			q.tim <= STP_TIM_RST;
			q.taddr_hi <= STP_TADDR_RST[6:2];
			q.lsb <= STP_TADDR_RST[1:0];
			q.glb <= STP_GLOBAL_RST;
			q.page <= STP_PAGE_RST;
			q.strap_s1 <= 2'h0;
			q.scl_d <= 1'b1;
			q.sda_d <= 1'b1;
			q.st <= STP_I2C_IDLE;
		end else begin
			q <= d;
		end
	end

	// open drain in i2c: only ever pull low
	always_comb begin
		if (q.glb[1:0] == STP_MODE_SPI) begin
			sdio_o = spi_o;
			sdio_oe = spi_oe;
		end else begin
			sdio_o = 1'b0;
			sdio_oe = q.drv_low && q.glb[1:0] == STP_MODE_I2C;
		end
	end

	assign i2c_slew_sel = q.fltr[STP_SPEED_LSB +: 2];
	assign port_mode = q.glb[1:0];
endmodule // stp_serial_port

/* stp_pkg.sv */
package stp_pkg;
	// register map of the serial target port, byte-wide registers
	localparam logic [15:0] STP_SPI_OPT_ADDR  = 16'h0040;
	localparam logic [15:0] STP_FLTR_ADDR     = 16'h0041;
	localparam logic [15:0] STP_TIM_ADDR      = 16'h0042;
	localparam logic [15:0] STP_TADDR_ADDR    = 16'h0043;
	localparam logic [15:0] STP_GLOBAL_ADDR   = 16'h0044;
	localparam logic [7:0]  STP_PAGE_LO       = 8'hfc;
	// reset values
	localparam logic [7:0]  STP_SPI_OPT_RST   = 8'h21;
	localparam logic [7:0]  STP_FLTR_RST      = 8'h01;
	localparam logic [7:0]  STP_TIM_RST       = 8'h44;
	localparam logic [7:0]  STP_TADDR_RST     = 8'h09;
	localparam logic [7:0]  STP_GLOBAL_RST    = 8'h01;
	localparam logic [7:0]  STP_PAGE_RST      = 8'h00;
	// writable bits and bits that are fixed to one
	localparam logic [7:0]  STP_SPI_OPT_WMASK = 8'h7a;
	localparam logic [7:0]  STP_SPI_OPT_FIXED = 8'h01;
	localparam logic [7:0]  STP_FLTR_WMASK    = 8'h3f;
	localparam logic [7:0]  STP_TADDR_WMASK   = 8'h7c;
	localparam logic [7:0]  STP_GLOBAL_WMASK  = 8'h07;
	// field positions
	localparam int STP_DUMMY_SIZE_LSB = 5;
	localparam int STP_DUMMY_EN_BIT   = 4;
	localparam int STP_DEL_OUT_BIT    = 3;
	localparam int STP_CLK_SEL_BIT    = 1;
	localparam int STP_SPEED_LSB      = 4;
	localparam int STP_HIGH_HOLD_LSB  = 4;
	localparam int STP_ADDR_SIZE_BIT  = 2;
	// port modes
	localparam logic [1:0] STP_MODE_OFF = 2'h0;
	localparam logic [1:0] STP_MODE_I2C = 2'h1;
	localparam logic [1:0] STP_MODE_SPI = 2'h2;
	// startup cycles before the strap pins are taken (synchroniser depth)
	localparam logic [1:0] STP_STRAP_WAIT = 2'h2;

	typedef enum logic [2:0] {
		STP_I2C_IDLE = 3'h0, STP_I2C_ADDR = 3'h1, STP_I2C_ADDR_ACK = 3'h3, STP_I2C_RX = 3'h2,
		STP_I2C_RX_ACK = 3'h6, STP_I2C_TX = 3'h7, STP_I2C_TX_ACK = 3'h5
	} stp_i2c_state_t;

	typedef enum logic [1:0] {
		STP_SPI_CMD = 2'h0, STP_SPI_AHI = 2'h1, STP_SPI_ALO = 2'h3, STP_SPI_DATA = 2'h2
	} stp_spi_phase_t;

	function automatic logic [7:0] stp_reg_read(input logic [15:0] a, input logic [7:0] page,
		input logic [7:0] spi_opt, input logic [7:0] fltr, input logic [7:0] tim,
		input logic [7:0] taddr, input logic [7:0] glb);
		logic [7:0] r;
		r = 8'h00;
		if (a[7:0] == STP_PAGE_LO) r = page;
		else if (a == STP_SPI_OPT_ADDR) r = spi_opt;
		else if (a == STP_FLTR_ADDR) r = fltr;
		else if (a == STP_TIM_ADDR) r = tim;
		else if (a == STP_TADDR_ADDR) r = taddr;
		else if (a == STP_GLOBAL_ADDR) r = glb;
		return r;
	endfunction
endpackage

/* stp_spike_filter.sv */
`timescale 1ns/1ps
module stp_spike_filter import stp_pkg::*; (
	input  wire logic       clk,      // system clock
	input  wire logic       reset_n,  // async reset
	input  wire logic       pin_i,    // raw pin level
	input  wire logic [3:0] len,      // filter length in cycles
	output logic            filt_o    // synchronised, filtered level
);
	typedef struct packed {
		logic       s1;
		logic       s2;
		logic [3:0] cnt;
		logic       out;
	} stp_filt_state_t;

	stp_filt_state_t q, d;

	always_comb begin
		d = q;
		d.s1 = pin_i;
		d.s2 = q.s1;
		if (len == 4'h0) begin
			d.out = q.s2;
			d.cnt = 4'h0;
		end else if (q.s2 == q.out) begin
			d.cnt = 4'h0;
		end else if (q.cnt + 4'h1 >= len) begin
			d.out = q.s2;
			d.cnt = 4'h0;
		end else begin
			d.cnt = q.cnt + 4'h1;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) q <= '{s1: 1'b1, s2: 1'b1, cnt: 4'h0, out: 1'b1};
		else q <= d;
	end

	assign filt_o = q.out;
endmodule // stp_spike_filter

/* stp_spi_link.sv */
`timescale 1ns/1ps
module stp_spi_link import stp_pkg::*; (
	input  wire logic        sclk,       // serial clock from host
	input  wire logic        cs_n,       // chip select, low in frame
	input  wire logic        reset_n,    // system reset
	input  wire logic        enable,     // spi mode selected
	input  wire logic        sdio_i,     // data pin level
	input  wire logic [7:0]  spi_opt,    // spi options register
	input  wire logic [7:0]  fltr,       // readback only
	input  wire logic [7:0]  tim,        // readback only
	input  wire logic [7:0]  taddr,      // readback only
	input  wire logic [7:0]  glb,        // global config register
	input  wire logic [7:0]  page,       // page register
	output logic             sdio_o,     // data pin drive value
	output logic             sdio_oe,    // data pin drive enable
	output logic             wr_toggle,  // flips once per written byte
	output logic [15:0]      wr_addr,    // address of written byte
	output logic [7:0]       wr_data     // written byte
);
	typedef struct packed {
		stp_spi_phase_t phase;
		logic [2:0]     bitcnt;
		logic           rw;
		logic [7:0]     hi;
		logic [15:0]    addr;
		logic [6:0]     shift;
		logic [1:0]     dummy;
		logic [7:0]     tx;
		logic           sending;
	} stp_spi_state_t;

	stp_spi_state_t q, d;
	logic samp_clk, link_rst, out_n, oe_n, out_p, oe_p;
	logic [7:0] byte_in;
	logic [1:0] dcount;

	// config is quasi-static: software changes it only between frames
	assign samp_clk = sclk ^ spi_opt[STP_CLK_SEL_BIT];
	assign link_rst = cs_n | ~reset_n | ~enable;
	assign byte_in = {q.shift, sdio_i};
	assign dcount = spi_opt[STP_DUMMY_EN_BIT] ? spi_opt[STP_DUMMY_SIZE_LSB +: 2] : 2'h0;

	always_comb begin
		d = q;
		d.shift = byte_in[6:0];
		d.bitcnt = q.bitcnt + 3'h1;
		if (q.bitcnt == 3'h7) begin
			case (q.phase)
			STP_SPI_CMD: begin
				d.rw = byte_in[7];
				d.phase = glb[STP_ADDR_SIZE_BIT] ? STP_SPI_AHI : STP_SPI_ALO;
			end
			STP_SPI_AHI: begin
				d.hi = byte_in;
				d.phase = STP_SPI_ALO;
			end
			STP_SPI_ALO: begin
				d.addr = {glb[STP_ADDR_SIZE_BIT] ? q.hi : page, byte_in};
				d.phase = STP_SPI_DATA;
				d.sending = q.rw;
				d.dummy = q.rw ? dcount : 2'h0;
				// no dummies: first data byte follows the address directly
				d.tx = (q.rw && dcount != 2'h0) ? 8'h00 :
					stp_reg_read(d.addr, page, spi_opt, fltr, tim, taddr, glb);
			end
			STP_SPI_DATA: begin
				if (q.rw && q.dummy > 2'h1) begin
					d.dummy = q.dummy - 2'h1;
					d.tx = 8'h00;
				end else if (q.rw && q.dummy == 2'h1) begin
					d.dummy = 2'h0;
					d.tx = stp_reg_read(q.addr, page, spi_opt, fltr, tim, taddr, glb);
				end else begin
					d.addr = q.addr + 16'h1;
					d.tx = stp_reg_read(d.addr, page, spi_opt, fltr, tim, taddr, glb);
				end
			end
			default: d.phase = STP_SPI_CMD;
			endcase
		end
	end

	always_ff @(posedge samp_clk or posedge link_rst) begin
		if (link_rst) q <= '0;
		else q <= d;
	end

	// toggle survives chip select so the system side sees every byte
	always_ff @(posedge samp_clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_toggle <= 1'b0;
			wr_addr <= 16'h0000;
			wr_data <= 8'h00;
		end else if (!cs_n && enable && q.phase == STP_SPI_DATA && !q.rw && q.bitcnt == 3'h7) begin
			wr_toggle <= ~wr_toggle;
			wr_addr <= q.addr;
			wr_data <= byte_in;
		end
	end

	// drive on the edge opposite sampling
	always_ff @(negedge samp_clk or posedge link_rst) begin
		if (link_rst) begin
			out_n <= 1'b0;
			oe_n <= 1'b0;
		end else begin
			out_n <= q.tx[~q.bitcnt];
			oe_n <= q.sending;
		end
	end

	// optional extra half cycle of delay
	always_ff @(posedge samp_clk or posedge link_rst) begin
		if (link_rst) begin
			out_p <= 1'b0;
			oe_p <= 1'b0;
		end else begin
			out_p <= out_n;
			oe_p <= oe_n;
		end
	end

	assign sdio_o = spi_opt[STP_DEL_OUT_BIT] ? out_p : out_n;
	assign sdio_oe = spi_opt[STP_DEL_OUT_BIT] ? oe_p : oe_n;
endmodule // stp_spi_link

/* stp_serial_port_properties.sv */
`timescale 1ns/1ps
module stp_serial_port_properties import stp_pkg::*; (
	input wire logic       clk,          // system clock
	input wire logic       reset_n,      // async reset
	input wire logic       scl_sclk,     // serial clock pin
	input wire logic       cs_n,         // chip select pin
	input wire logic       sdio_i,       // data wire level
	input wire logic       sdio_o,       // data drive value
	input wire logic       sdio_oe,      // data drive enable
	input wire logic [1:0] otp_addr_lsb, // otp address bits
	input wire logic       strap_en,     // strap override
	input wire logic [1:0] strap_addr,   // strap pins
	input wire logic [1:0] i2c_slew_sel, // slew select
	input wire logic [1:0] port_mode     // active mode
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	wire logic i2c_on = port_mode == STP_MODE_I2C;
	wire logic spi_on = port_mode == STP_MODE_SPI;

	AST_OFF_QUIET:
		assert property (port_mode == STP_MODE_OFF && $past(port_mode) == STP_MODE_OFF
			|-> !sdio_oe) else $error("port off but data pin driven");
	AST_I2C_OPEN_DRAIN:
		assert property (i2c_on |-> sdio_o == 1'b0) else $error("i2c drives a high level");
	AST_RESET_VALUES:
		assert property ($rose(reset_n) |-> i2c_slew_sel == 2'h0 && i2c_on && !sdio_oe)
			else $error("wrong values after reset");
	AST_CS_QUIET:
		assert property (spi_on && cs_n && $past(cs_n) |-> !sdio_oe)
			else $error("data pin driven outside frame");
	AST_SPI_OE_FRAME:
		assert property (spi_on && $rose(sdio_oe) |-> !cs_n) else $error("drive starts unselected");
	AST_I2C_CHANGE_LOW:
		assert property (i2c_on && $changed(sdio_oe) |-> !scl_sclk)
			else $error("sda changed while scl high");
	AST_SYNC_GAP:
		assert property (i2c_on && $fell(scl_sclk) |=> $stable(sdio_oe)[*3])
			else $error("sda reacts before scl synchronised");
	AST_SLEW_LOW:
		assert property (i2c_on && $changed(i2c_slew_sel) |-> !scl_sclk)
			else $error("slew changed mid bit");
	C_ACK: cover property (i2c_on && $rose(sdio_oe));
	C_SPI_DRIVE: cover property (spi_on && $rose(sdio_oe));
	C_FMP: cover property (i2c_slew_sel == 2'h3);
endmodule // stp_serial_port_properties

bind stp_serial_port stp_serial_port_properties u_props (.clk(clk), .reset_n(reset_n),
	.scl_sclk(scl_sclk), .cs_n(cs_n), .sdio_i(sdio_i), .sdio_o(sdio_o), .sdio_oe(sdio_oe),
	.otp_addr_lsb(otp_addr_lsb), .strap_en(strap_en), .strap_addr(strap_addr),
	.i2c_slew_sel(i2c_slew_sel), .port_mode(port_mode));

/* stp_host_model.sv */
`timescale 1ns/1ps
module stp_host_model (
	input  wire logic clk,  // system clock
	input  wire logic sda,  // resolved data wire
	input  wire logic oe,   // device drive enable
	output logic      scl,  // scl / sclk pin
	output logic      cs_n, // chip select
	output logic      h_oe, // host drives wire
	output logic      h_d   // host drive value
);
	int   lat_drv = -1;
	int   lat_rel = -1;
	logic late = 1'b0;  // sample just before the falling sclk edge
	initial begin
		scl = 1'b1;
		cs_n = 1'b1;
		h_oe = 1'b0;
		h_d = 1'b0;
	end
	task automatic q(input int n);
		repeat (n) @(negedge clk);
	endtask
	// 100 kHz-class bit; low phase also times the device's drive edges
	task automatic bit_x(input logic b, output logic r);
		logic o;
		o = oe;
		h_d = 1'b0;
		h_oe = !b;
		for (int k = 0; k < 44; k++) begin
			@(negedge clk);
			if (oe !== o) begin
				if (o) lat_rel = k;
				else lat_drv = k;
				o = oe;
			end
		end
		scl = 1'b1;
		q(22);
		r = sda;
		q(22);
		scl = 1'b0;
	endtask
	// long first wait: the device may still hold sda from its last ack
	task automatic start();
		h_d = 1'b0;
		h_oe = 1'b0;
		q(44);
		scl = 1'b1;
		q(22);
		h_oe = 1'b1;
		q(22);
		scl = 1'b0;
	endtask
	task automatic stop();
		h_oe = 1'b1;
		q(44);
		scl = 1'b1;
		q(22);
		h_oe = 1'b0;
		q(22);
	endtask
	task automatic byte_w(input logic [7:0] d, inout logic ok);
		logic r;
		for (int i = 7; i >= 0; i--) bit_x(d[i], r);
		bit_x(1'b1, r);
		ok &= !r;
	endtask
	task automatic i2c_wr(input logic [6:0] dv, input logic [7:0] a, d, output logic ok);
		ok = 1'b1;
		start();
		byte_w({dv, 1'b0}, ok);
		byte_w(a, ok);
		byte_w(d, ok);
		stop();
	endtask
	task automatic i2c_rd(input logic [6:0] dv, input logic [7:0] a, output logic [7:0] d,
		output logic ok);
		logic r;
		ok = 1'b1;
		start();
		byte_w({dv, 1'b0}, ok);
		byte_w(a, ok);
		start();
		byte_w({dv, 1'b1}, ok);
		for (int i = 7; i >= 0; i--) begin
			bit_x(1'b1, r);
			d[i] = r;
		end
		bit_x(1'b1, r);
		stop();
	endtask
	// sclk idles low and runs only inside frames
	// data changes mid low phase so either sampling edge sees it settled
	task automatic sbit(input logic b, output logic r);
		#40;
		h_d = b;
		#40;
		r = sda;
		scl = 1'b1;
		#80;
		if (late) r = sda;
		scl = 1'b0;
	endtask
	task automatic spi(input logic rd, input int na, input logic [15:0] a, input logic [7:0] wd,
		input int nd, output logic [7:0] d, output logic dz);
		logic r;
		dz = 1'b0;
		d = 8'h00;
		scl = 1'b0;
		#37;
		cs_n = 1'b0;
		h_oe = 1'b1;
		for (int i = 7; i >= 0; i--) sbit(i == 7 && rd, r);
		for (int i = 8 * na - 1; i >= 0; i--) sbit(a[i], r);
		#20;
		h_oe = !rd;  // single shared data wire
		for (int i = rd ? 8 * nd + 7 : 7; i >= 0; i--) begin
			sbit(wd[i % 8], r);
			if (i < 8) d = {d[6:0], r};
			else dz = dz | r;
		end
		#80;
		cs_n = 1'b1;
		h_oe = 1'b0;
		q(10);
	endtask
endmodule // stp_host_model

/* stp_serial_port_tb.sv */
`timescale 1ns/1ps
module stp_serial_port_tb import stp_pkg::*; ;
	logic       clk, reset_n, strap_en;
	logic [1:0] otp, strap;
	wire logic  scl, cs_n, sdio_o, sdio_oe, h_oe, h_d;
	wire logic [1:0] slew, pmode;
	wire logic  sdio_i = sdio_oe ? sdio_o : (h_oe ? h_d : 1'b1);
	int         n_fail = 0;
	int         n_compared = 0;

	stp_serial_port DUT (.clk(clk), .reset_n(reset_n), .scl_sclk(scl), .cs_n(cs_n),
		.sdio_i(sdio_i), .sdio_o(sdio_o), .sdio_oe(sdio_oe), .otp_addr_lsb(otp),
		.strap_en(strap_en), .strap_addr(strap), .i2c_slew_sel(slew), .port_mode(pmode));
	stp_host_model host (.clk(clk), .sda(sdio_i), .oe(sdio_oe), .scl(scl), .cs_n(cs_n),
		.h_oe(h_oe), .h_d(h_d));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic finish_test();
		$display("compared %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [15:0] g, e);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("Error at %0t: got %h, expected %h", $time, g, e);
		end
	endtask
	task automatic rng(input int g, lo, hi);
		n_compared++;
		if (g < lo || g > hi) begin
			n_fail++;
			$display("Error at %0t: got %h, expected %h to %h", $time, g, lo, hi);
		end
	endtask
	task automatic iw(input logic [6:0] dv, input logic [7:0] a, d, input logic eok);
		logic ok;
		host.i2c_wr(dv, a, d, ok);
		chk({15'h0, ok}, {15'h0, eok});
	endtask
	task automatic ir(input logic [6:0] dv, input logic [7:0] a, e);
		logic [7:0] d;
		logic ok;
		host.i2c_rd(dv, a, d, ok);
		chk({7'h00, ok, d}, {8'h01, e});
	endtask
	task automatic sw(input int na, input logic [15:0] a, input logic [7:0] d);
		logic [7:0] r;
		logic dz;
		host.spi(1'b0, na, a, d, 0, r, dz);
	endtask
	task automatic sr(input int na, input logic [15:0] a, input int nd, input logic [7:0] e);
		logic [7:0] r;
		logic dz;
		host.spi(1'b1, na, a, 8'h00, nd, r, dz);
		chk({7'h00, dz, r}, {8'h00, e});
	endtask
	task automatic do_reset();
		reset_n = 1'b0;
		repeat (20) @(negedge clk);
		reset_n = 1'b1;
		repeat (4) @(negedge clk);
	endtask
	// no wait in the sequence is open-ended; this guard caps the whole run
	initial begin
		#9ms;
		n_fail++;
		finish_test();
	end
	initial begin
		logic ok;
		otp = 2'h1;
		strap_en = 1'b0;
		strap = 2'h2;
		do_reset();
		chk({14'h0000, pmode}, {14'h0000, STP_MODE_I2C});
		chk({14'h0000, slew}, 16'h0000);
		ir(7'h09, 8'h40, STP_SPI_OPT_RST);
		ir(7'h09, 8'h41, STP_FLTR_RST);
		ir(7'h09, 8'h42, STP_TIM_RST);
		ir(7'h09, 8'h44, STP_GLOBAL_RST);
		rng(host.lat_drv, 32, 40);
		rng(host.lat_rel, 32, 40);
		$display("test reset_values done");
		iw(7'h0a, 8'h42, 8'h31, 1'b0);
		iw(7'h09, 8'h42, 8'h31, 1'b1);
		iw(7'h09, STP_PAGE_LO, 8'h00, 1'b1);
		rng(host.lat_drv, 8, 16);
		rng(host.lat_rel, 24, 32);
		$display("test hold_timing done");
		for (int c = 0; c < 4; c++) begin
			iw(7'h09, 8'h41, 8'(c * 19), 1'b1);
			chk({14'h0000, slew}, {14'h0000, 2'(c)});
		end
		ir(7'h09, 8'h41, 8'h39);
		iw(7'h09, 8'h43, 8'hff, 1'b1);
		ir(7'h7d, 8'h43, 8'h7d);
		iw(7'h09, 8'h41, 8'h01, 1'b0);
		$display("test i2c_config done");
		// the mode flips before the data ack, so that ack is not judged
		host.i2c_wr(7'h7d, 8'h44, 8'h02, ok);
		chk({14'h0000, pmode}, {14'h0000, STP_MODE_SPI});
		sr(1, 16'h0041, 0, 8'h39);
		for (int s = 1; s < 4; s++) begin
			sw(1, 16'h0040, 8'(s * 32 + 16));
			sr(1, 16'h0040, s, 8'(s * 32 + 17));
		end
		sw(1, 16'h0040, 8'h00);
		sr(1, 16'h0040, 0, 8'h01);
		sw(1, 16'h0040, 8'h08);
		host.late = 1'b1;
		sr(1, 16'h0042, 0, 8'h31);
		sw(1, 16'h0040, 8'h02);
		sr(1, 16'h0042, 0, 8'h31);
		host.late = 1'b0;
		sw(1, 16'h0040, 8'h00);
		sw(1, 16'h0050, 8'haa);
		sr(1, 16'h0050, 0, 8'h00);
		sw(1, STP_GLOBAL_ADDR, 8'h06);
		sr(2, STP_TADDR_ADDR, 0, 8'h7d);
		sw(2, STP_GLOBAL_ADDR, 8'h00);
		chk({14'h0000, pmode}, {14'h0000, STP_MODE_OFF});
		$display("test spi_link done");
		strap_en = 1'b1;
		do_reset();
		ir(7'h0a, 8'h43, 8'h0a);
		$display("test strap_address done");
		finish_test();
	end
endmodule // stp_serial_port_tb
